// >>> design/ssa_pkg.sv
// Package for the serial absolute angle readout: frame layout, timing.
// Assumes a single 100 MHz clock domain in the design that imports it.
`default_nettype none
package ssa_pkg;
  localparam int unsigned REF_CLK_MHZ = 100;
  localparam int unsigned TIMEOUT_US = 16;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * REF_CLK_MHZ;
  localparam int unsigned ANGLE_BITS = 12;
  localparam int unsigned CHECK_BITS = 6;
  localparam int unsigned RSVD_BITS = 2;
  localparam int unsigned HEAD_BITS = 3;
  localparam int unsigned FRAME_BITS =
    HEAD_BITS + ANGLE_BITS + RSVD_BITS + CHECK_BITS;
  localparam logic [2:0] HEAD_VALUE = 3'h6;
  localparam logic [1:0] RSVD_VALUE = 2'h0;
  localparam logic [5:0] CHECK_INIT = 6'h00;
  localparam logic [5:0] CHECK_POLY = 6'h03;

  typedef enum logic [1:0] {IDLE, SHIFT, HOLD} ssa_state_type;

  typedef struct packed {
    logic clkSync1;
    logic clkSync2;
    logic clkPrev;
  } ssa_sync_type;

  typedef struct packed {
    ssa_state_type state;
    ssa_sync_type sync;
    logic [FRAME_BITS-1:0] shiftReg;
    logic [4:0] bitCnt;
    logic [5:0] check;
    logic [10:0] idleCnt;
    logic dataOut;
    logic busy;
  } ssa_reg_type;
endpackage : ssa_pkg
`default_nettype wire

// >>> design/ssa_readout.sv
// Encoder side of the synchronous serial angle readout.
// Assumes the controller clock arrives asynchronously on serClk.
`default_nettype none
// Notes on behaviour
// RQ1: Each frame opens with acknowledge, start and frame control bit.
// RQ2: Then the 12-bit binary angle follows, one bit per controller clock.
// RQ3: Then two reserved bits and six check bits end the frame.
// RQ4: With no clock edge for 16 us the transfer ends.
// RQ5: The controller may stop after the angle and rely on the timeout.
// RQ6: Angle rises with clockwise output shaft rotation.
// RQ7: Controller drives the clock; the encoder only drives data.
// RQ8: Controller idles the clock at least the timeout before a new readout.
module ssa_readout
  import ssa_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = ssa_pkg::TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Angle from the sensing front end, clockwise counts up.
  input wire logic [ssa_pkg::ANGLE_BITS-1:0] angleIn,
  // Serial link.
  input wire logic serClk,
  output logic serData,
  // Status.
  output logic frameBusy
);
  import ssa_pkg::*;

  ssa_reg_type r_ff;
  ssa_reg_type nxt_r;
  logic fallEdge;
  logic riseEdge;
  logic [FRAME_BITS-1:0] frame;
  logic [5:0] chk;

  // Serial check over the data bits of one frame, MSB first.
  function automatic logic [5:0] check_step(logic [5:0] c, logic b);
    logic fb;
    fb = c[5] ^ b;
    check_step = {c[4:0], 1'b0} ^ (fb ? CHECK_POLY : 6'h00);
  endfunction

  always_comb begin
    chk = CHECK_INIT;
    // The check covers angle and reserved bits. [RQ3]
    for (int i = ANGLE_BITS - 1; i >= 0; i--) begin
      chk = check_step(chk, angleIn[i]);
    end
    for (int i = RSVD_BITS - 1; i >= 0; i--) begin
      chk = check_step(chk, RSVD_VALUE[i]);
    end
    // Opening sequence, angle, reserved, check. [RQ1] [RQ2] [RQ3] [RQ6]
    frame = {HEAD_VALUE, angleIn, RSVD_VALUE, chk};
  end

  // The link clock is only sampled; the encoder never drives it. [RQ7]
  assign fallEdge = r_ff.sync.clkPrev & ~r_ff.sync.clkSync2;
  assign riseEdge = ~r_ff.sync.clkPrev & r_ff.sync.clkSync2;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sync.clkSync1 = serClk;
    nxt_r.sync.clkSync2 = r_ff.sync.clkSync1;
    nxt_r.sync.clkPrev = r_ff.sync.clkSync2;
    if (riseEdge || fallEdge) begin
      nxt_r.idleCnt = '0;
    end else if (r_ff.idleCnt != 11'h7FF) begin
      nxt_r.idleCnt = r_ff.idleCnt + 11'h001;
    end
    case (r_ff.state)
      IDLE: begin
        nxt_r.dataOut = 1'b1;
        nxt_r.busy = 1'b0;
        if (fallEdge) begin
          // Angle is latched at the first falling edge. [RQ1]
          nxt_r.shiftReg = frame;
          nxt_r.check = chk;
          nxt_r.bitCnt = '0;
          nxt_r.busy = 1'b1;
          nxt_r.state = SHIFT;
        end
      end
      SHIFT: begin
        if (riseEdge) begin
          // One bit per controller clock. [RQ2]
          nxt_r.dataOut = r_ff.shiftReg[FRAME_BITS-1];
          nxt_r.shiftReg = {r_ff.shiftReg[FRAME_BITS-2:0], 1'b0};
          nxt_r.bitCnt = r_ff.bitCnt + 5'h01;
          if (r_ff.bitCnt == 5'(FRAME_BITS - 1)) begin
            nxt_r.state = HOLD;
          end
        end
        // Clock stopped early, e.g. after the angle. [RQ4] [RQ5]
        if (32'(r_ff.idleCnt) >= TIMEOUT_CYCLES - 1) begin
          nxt_r.state = IDLE;
          nxt_r.dataOut = 1'b1;
          nxt_r.busy = 1'b0;
        end
      end
      HOLD: begin
        if (riseEdge) begin
          nxt_r.dataOut = 1'b0;
        end
        // Frame closes only after the idle timeout. [RQ4]
        if (32'(r_ff.idleCnt) >= TIMEOUT_CYCLES - 1) begin
          nxt_r.state = IDLE;
          nxt_r.dataOut = 1'b1;
          nxt_r.busy = 1'b0;
        end
      end
      default: begin
        nxt_r.state = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_ff.state <= IDLE;
      r_ff.sync <= 3'h7;
      r_ff.shiftReg <= '0;
      r_ff.bitCnt <= '0;
      r_ff.check <= CHECK_INIT;
      r_ff.idleCnt <= '0;
      r_ff.dataOut <= 1'b1;
      r_ff.busy <= 1'b0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign serData = r_ff.dataOut;
  assign frameBusy = r_ff.busy;

  // The idle counter has reached the limit while bits are still due.
  sequence s_idle_long;
    r_ff.state == SHIFT && 32'(r_ff.idleCnt) >= TIMEOUT_CYCLES - 1;
  endsequence

  // A falling link clock edge seen while the link is at rest.
  sequence s_load;
    r_ff.state == IDLE && fallEdge;
  endsequence

  // A rising edge that shifts bit n of the frame, clear of the timeout.
  sequence s_shift_rise(int n);
    r_ff.state == SHIFT && riseEdge && r_ff.bitCnt == 5'(n)
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1;
  endsequence

  AST_TIMEOUT_ENDS: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (!rst_n)
    s_idle_long |=> !frameBusy && serData)
    else $error("transfer not ended after idle timeout");
  AST_START_BUSY: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rst_n)
    s_load |=> frameBusy)
    else $error("frame did not start on first falling edge");
  AST_IDLE_HIGH: assert property ( // [RQ7]
    @(posedge ref_clk) disable iff (!rst_n)
    !frameBusy |-> serData)
    else $error("data not high while idle");
  AST_SHIFT_ON_RISE: assert property ( // [RQ2]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state == SHIFT && riseEdge
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> serData == $past(r_ff.shiftReg[FRAME_BITS-1]))
    else $error("data bit not shifted on rising edge");
  AST_COUNT_STEP: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state == SHIFT && riseEdge && r_ff.bitCnt < 5'(FRAME_BITS - 1)
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> r_ff.bitCnt == $past(r_ff.bitCnt) + 5'h01)
    else $error("bit counter did not advance");
  AST_FRAME_LEN: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state == SHIFT && riseEdge && r_ff.bitCnt == 5'(FRAME_BITS - 1)
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> r_ff.state == HOLD)
    else $error("frame length wrong");
  AST_HEAD_LOAD: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rst_n)
    s_load
      |=> r_ff.shiftReg[FRAME_BITS-1 -: 3] == HEAD_VALUE)
    else $error("opening sequence not loaded");
  AST_ANGLE_LOAD: assert property ( // [RQ6]
    @(posedge ref_clk) disable iff (!rst_n)
    s_load |=>
      r_ff.shiftReg[FRAME_BITS-4 -: ANGLE_BITS] == $past(angleIn))
    else $error("angle not loaded");

  // The opening sequence leaves in order on the first three rises.
  AST_ACK_BIT: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rst_n)
    s_shift_rise(0) |=> serData == HEAD_VALUE[2])
    else $error("acknowledge bit wrong");
  AST_START_BIT: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rst_n)
    s_shift_rise(1) |=> serData == HEAD_VALUE[1])
    else $error("start bit wrong");
  AST_FRAME_CONTROL_BIT: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rst_n)
    s_shift_rise(2) |=> serData == HEAD_VALUE[0])
    else $error("frame control bit wrong");

  // The tail of the frame holds the reserved bits and the check word.
  AST_RSVD_LOAD: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rst_n)
    s_load |=> r_ff.shiftReg[CHECK_BITS +: RSVD_BITS] == RSVD_VALUE)
    else $error("reserved bits not loaded");
  AST_CHECK_LOAD: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rst_n)
    s_load |=> r_ff.shiftReg[CHECK_BITS-1:0] == r_ff.check)
    else $error("check bits not loaded");
  AST_HOLD_LOW: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state == HOLD && riseEdge
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> !serData)
    else $error("data not low after the frame");

  // The transfer only ends through the idle timeout.
  AST_BUSY_HOLDS: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state != IDLE
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> frameBusy)
    else $error("transfer ended before the idle timeout");
  AST_EDGE_CLEARS: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (!rst_n)
    (riseEdge || fallEdge) |=> r_ff.idleCnt == 11'h000)
    else $error("idle counter not cleared by a clock edge");
  AST_DATA_STABLE: assert property ( // [RQ2]
    @(posedge ref_clk) disable iff (!rst_n)
    (r_ff.state == SHIFT && !riseEdge
      && 32'(r_ff.idleCnt) < TIMEOUT_CYCLES - 1)
      |=> $stable(serData))
    else $error("data changed without a rising edge");
endmodule // ssa_readout
`default_nettype wire

// >>> sim/ssa_ctrl_model.sv
// Controller model: drives the serial clock and gathers the data bits.
// Assumes the bench waits out the idle timeout between two reads.
`default_nettype none
module ssa_ctrl_model (
  // Serial link.
  output logic serClk,
  input wire logic serData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial serClk = 1'b1;
  // Clocks n bits in, samples 80 ns after each rise, stops high.
  task automatic readFrame(input int n, output logic [22:0] bits);
    bits = '0;
    #3;
    repeat (n) begin
      serClk = 1'b0;
      #80 serClk = 1'b1;
      #80 bits = {bits[21:0], serData};
    end
  endtask
endmodule : ssa_ctrl_model
`default_nettype wire

// >>> sim/ssa_readout_test.sv
// Self-checking bench for the serial angle readout.
// Assumes a shortened timeout of 40 cycles and a 160 ns link clock.
`default_nettype none
module ssa_readout_test;
  import ssa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 40;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] angleIn = 12'h000;
  logic serClk;
  logic serData;
  logic frameBusy;
  int n_errors = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  ssa_readout #(.TIMEOUT_CYCLES(TO)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .angleIn(angleIn), .serClk(serClk), .serData(serData),
    .frameBusy(frameBusy));
  ssa_ctrl_model ctrl (.serClk(serClk), .serData(serData));
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    c = CHECK_INIT;
    for (int k = 13; k >= 0; k--)
      c = {c[4:0], 1'b0} ^ ((c[5] ^ d[k]) ? CHECK_POLY : 6'h00);
    return c;
  endfunction
  // Keeps the clock still until the link is back at rest.
  task automatic idleEnd();
    int i;
    repeat (TO - 10) @(posedge ref_clk);
    #1 check(frameBusy, 1'b1);
    for (i = 0; i < 40 && frameBusy !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check({frameBusy, serData}, 2'h1);
    if (i == 40)
      conclude();
  endtask
  // Reads n bits for angle a and compares them with the frame layout.
  task automatic frame(input logic [11:0] a, input int n);
    logic [22:0] bits;
    logic [22:0] exp;
    @(posedge ref_clk);
    #1 angleIn = a;
    exp = {HEAD_VALUE, a, RSVD_VALUE, crc6({a, RSVD_VALUE})};
    ctrl.readFrame(n, bits);
    check(frameBusy, 1'b1);
    check(bits, exp >> (23 - n));
    idleEnd();
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check({frameBusy, serData}, 2'h1);
    frame(12'hFFF, 23);
    frame(12'h001, 15);
    frame(12'h002, 23);
    frame(12'hA5C, 23);
    conclude();
  end
endmodule : ssa_readout_test
`default_nettype wire
